/* File: dma_req_defines.vh */
`ifndef DMA_REQ_DEFINES_VH
`define DMA_REQ_DEFINES_VH

`define SEL_AUTO        4'h1
`define SEL_EXT_DUAL    4'h0
`define SEL_EXT_MEM2DEV 4'h2
`define SEL_EXT_DEV2MEM 4'h3
`define SEL_TMR0        4'h6
`define SEL_TMR4        4'ha
`define SEL_ADC         4'hb
`define SEL_S0_TX       4'hc
`define SEL_S0_RX       4'hd
`define SEL_S1_TX       4'he
`define SEL_S1_RX       4'hf
`define PERIPH_COUNT    10
`define PERIPH_BASE     4'h6
`define SEL_RSVD_A      4'h4
`define SEL_RSVD_B      4'h5
`define ADDR_DUAL       2'h0
`define ADDR_SINGLE_WR  2'h1
`define ADDR_SINGLE_RD  2'h2
`define ADDR_NONE       2'h3

`endif

/* File: ext_request_detect.v */
`timescale 1ns/10ps
`include "dma_req_defines.vh"

module ext_request_detect (
	input  wire clk_sys_in,
	input  wire resetn_in,
	input  wire external_request_n_in,
	input  wire request_detect_select_in,
	output reg  ext_req_out
);
	reg sync1_q;
	reg sync2_q;
	reg prev_q;

	always @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
			prev_q  <= 1'b1;
			ext_req_out <= 1'b0;
		end else begin
			sync1_q <= external_request_n_in;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
			// level when 0, falling edge when 1
			if (request_detect_select_in) begin
				ext_req_out <= prev_q & ~sync2_q;
			end else begin
				ext_req_out <= ~sync2_q;
			end
		end
	end
endmodule // ext_request_detect

/* File: dma_request_source_select.v */
`timescale 1ns/10ps
`include "dma_req_defines.vh"

module dma_request_source_select #(
	parameter PERIPH_N = `PERIPH_COUNT
) (
	input  wire                clk_sys_in,
	input  wire                resetn_in,
	input  wire [3:0]          request_select_in,
	input  wire                request_detect_select_in,
	input  wire                channel_enable_bit_in,
	input  wire                master_enable_bit_in,
	input  wire                transfer_end_flag_in,
	input  wire                nmi_seen_flag_in,
	input  wire                address_error_flag_in,
	input  wire                burst_mode_in,
	input  wire                transfer_done_in,
	input  wire                last_transfer_in,
	input  wire                external_request_n_in,
	input  wire [PERIPH_N-1:0] periph_irq_in,
	output reg                 transfer_request_out,
	output reg  [1:0]          address_mode_out,
	output reg  [3:0]          pair_check_out,
	output reg  [PERIPH_N-1:0] cpu_irq_out,
	output reg  [PERIPH_N-1:0] periph_clear_out,
	output reg                 suspend_out
);
	reg  [PERIPH_N-1:0] irq_s1_q;
	reg  [PERIPH_N-1:0] irq_s2_q;
	reg                 en_q;
	wire                ext_req;
	wire                enabled;
	wire                sel_auto;
	wire                sel_periph;
	wire                sel_ext;
	wire                sel_unused;
	wire                periph_hit;
	wire                clear_due;
	reg                 req_d;
	reg  [1:0]          amode_d;
	reg  [3:0]          pair_d;
	reg  [PERIPH_N-1:0] sel_onehot;
	reg  [PERIPH_N-1:0] cpu_d;
	reg  [PERIPH_N-1:0] clear_d;
	reg                 suspend_d;

	// timer, adc and serial codes sit above the external and reserved ones
	function is_periph_code;
		input [3:0] code;
		begin
			is_periph_code = (code >= `SEL_TMR0);
		end
	endfunction

	function is_ext_code;
		input [3:0] code;
		begin
			is_ext_code = (code == `SEL_EXT_DUAL) ||
				(code == `SEL_EXT_MEM2DEV) ||
				(code == `SEL_EXT_DEV2MEM);
		end
	endfunction

	function is_unused_code;
		input [3:0] code;
		begin
			is_unused_code = (code == `SEL_RSVD_A) ||
				(code == `SEL_RSVD_B);
		end
	endfunction

	// bit position of a peripheral code in the irq vector
	function [3:0] periph_index;
		input [3:0] code;
		begin
			periph_index = code - `PERIPH_BASE;
		end
	endfunction

	// only one bit at most, so a stray code cannot clear two requests
	function [PERIPH_N-1:0] periph_onehot;
		input   [3:0] code;
		integer       k;
		begin
			periph_onehot = {PERIPH_N{1'b0}};
			for (k = 0; k < PERIPH_N; k = k + 1) begin
				if (periph_index(code) == k[3:0]) begin
					periph_onehot[k] = is_periph_code(code);
				end
			end
		end
	endfunction

	// address mode that the code fixes, none for codes without a request
	function [1:0] addr_mode_of;
		input [3:0] code;
		begin
			case (code)
			`SEL_AUTO: begin
				addr_mode_of = `ADDR_DUAL;
			end
			`SEL_EXT_DUAL: begin
				addr_mode_of = `ADDR_DUAL;
			end
			`SEL_EXT_MEM2DEV: begin
				addr_mode_of = `ADDR_SINGLE_WR;
			end
			`SEL_EXT_DEV2MEM: begin
				addr_mode_of = `ADDR_SINGLE_RD;
			end
			`SEL_RSVD_A, `SEL_RSVD_B: begin
				addr_mode_of = `ADDR_NONE;
			end
			default: begin
				addr_mode_of = `ADDR_DUAL;
			end
			endcase
		end
	endfunction

	ext_request_detect u_ext (
		.clk_sys_in               (clk_sys_in),
		.resetn_in                (resetn_in),
		.external_request_n_in    (external_request_n_in),
		.request_detect_select_in (request_detect_select_in),
		.ext_req_out              (ext_req)
	);

	// one gate for every mode
	assign enabled = channel_enable_bit_in & master_enable_bit_in &
		~transfer_end_flag_in & ~nmi_seen_flag_in &
		~address_error_flag_in;
	assign sel_auto   = (request_select_in == `SEL_AUTO);
	assign sel_periph = is_periph_code(request_select_in);
	assign sel_ext    = is_ext_code(request_select_in);
	assign sel_unused = is_unused_code(request_select_in);
	assign periph_hit = |(irq_s2_q & sel_onehot);
	// steal clears on first transfer, burst waits for the last
	assign clear_due  = transfer_done_in &
		(~burst_mode_in | last_transfer_in);

	always @* begin
		sel_onehot = periph_onehot(request_select_in);
	end

	always @* begin
		req_d = 1'b0;
		pair_d = 4'h0;
		amode_d = addr_mode_of(request_select_in);
		if (sel_auto) begin
			req_d = enabled;
		end else if (sel_ext) begin
			req_d = enabled & ext_req;
		end else if (sel_unused) begin
			req_d = 1'b0;
		end else if (sel_periph) begin
			// pairing shown for software to honour
			req_d = enabled & periph_hit;
			pair_d = request_select_in;
		end
	end

	always @* begin
		cpu_d = irq_s2_q & ~sel_onehot;
		clear_d = {PERIPH_N{1'b0}};
		if (clear_due) begin
			clear_d = sel_onehot;
		end
		suspend_d = en_q & ~channel_enable_bit_in;
	end

	// peripheral irqs come from other clock trees, two flops before use
	always @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			irq_s1_q <= {PERIPH_N{1'b0}};
			irq_s2_q <= {PERIPH_N{1'b0}};
		end else begin
			irq_s1_q <= periph_irq_in;
			irq_s2_q <= irq_s1_q;
		end
	end

	always @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			transfer_request_out <= 1'b0;
			address_mode_out <= `ADDR_NONE;
			pair_check_out <= 4'h0;
		end else begin
			transfer_request_out <= req_d;
			address_mode_out <= amode_d;
			pair_check_out <= pair_d;
		end
	end

	always @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cpu_irq_out <= {PERIPH_N{1'b0}};
			periph_clear_out <= {PERIPH_N{1'b0}};
		end else begin
			cpu_irq_out <= cpu_d;
			periph_clear_out <= clear_d;
		end
	end

	// enable history only; a fall outside a transfer pulses as well
	always @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			en_q <= 1'b0;
			suspend_out <= 1'b0;
		end else begin
			en_q <= channel_enable_bit_in;
			suspend_out <= suspend_d;
		end
	end
endmodule // dma_request_source_select

/* File: dma_req_chk_assertions.sv */
`timescale 1ns/10ps
module dma_req_chk #(parameter PERIPH_N = 10) (
	input wire                clk_sys_in,
	input wire                resetn_in,
	input wire [3:0]          request_select_in,
	input wire                channel_enable_bit_in,
	input wire                master_enable_bit_in,
	input wire                transfer_end_flag_in,
	input wire                nmi_seen_flag_in,
	input wire                address_error_flag_in,
	input wire                burst_mode_in,
	input wire                transfer_done_in,
	input wire                last_transfer_in,
	input wire                transfer_request_out,
	input wire [1:0]          address_mode_out,
	input wire [3:0]          pair_check_out,
	input wire [PERIPH_N-1:0] cpu_irq_out,
	input wire [PERIPH_N-1:0] periph_clear_out,
	input wire                suspend_out
);
	wire [3:0] sel = request_select_in;
	wire       go  = channel_enable_bit_in & master_enable_bit_in &
		~transfer_end_flag_in & ~nmi_seen_flag_in & ~address_error_flag_in;
	wire       pd  = sel >= 4'h6 && transfer_done_in;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);
	auto_request_a: assert property (sel == 4'h1 && go |=> transfer_request_out)
		else $error("auto request missing");
	gate_block_a: assert property (!go |=> !transfer_request_out)
		else $error("request while blocked");
	unused_code_a: assert property (sel inside {4'h4, 4'h5} |=> !transfer_request_out)
		else $error("request on unused code");
	dual_mode_a: assert property (sel == 4'h0 |=> address_mode_out == 2'h0)
		else $error("dual mode wrong");
	single_mode_a: assert property (sel inside {4'h2, 4'h3} |=> address_mode_out == $past(sel) - 4'h1)
		else $error("single mode wrong");
	pair_code_a: assert property (sel >= 4'h6 |=> pair_check_out == $past(sel))
		else $error("pair code wrong");
	cpu_mask_a: assert property (pair_check_out >= 4'h6 |-> !cpu_irq_out[pair_check_out - 4'h6])
		else $error("selected irq reached cpu");
	burst_hold_a: assert property (pd && burst_mode_in && !last_transfer_in |=> periph_clear_out == 0)
		else $error("early burst clear");
	steal_clear_a: assert property (pd && !burst_mode_in |=> periph_clear_out[$past(sel) - 4'h6])
		else $error("steal clear missing");
	suspend_a: assert property ($fell(channel_enable_bit_in) |=> suspend_out)
		else $error("suspend missing");
	cover property (sel == 4'h1 && go ##1 transfer_request_out);
	cover property (suspend_out);
	cover property (periph_clear_out != 0);
endmodule // dma_req_chk
bind dma_request_source_select dma_req_chk #(.PERIPH_N(PERIPH_N)) chk (.*);

/* File: req_partner.sv */
`timescale 1ns/10ps
module req_partner (
	input  wire       clk_sys_in,
	input  wire [9:0] raise_in,
	input  wire [9:0] clear_in,
	input  wire       ext_in,
	output reg  [9:0] irq_out = 10'h000,
	output wire       ext_n_out
);
	// irq level holds until the controller clears it
	always @(posedge clk_sys_in)
		irq_out <= (irq_out | raise_in) & ~clear_in;
	assign ext_n_out = ~ext_in;
endmodule // req_partner

/* File: tb_dma_request_source_select.sv */
`timescale 1ns/10ps
module tb_dma_request_source_select;
	logic clk = 0, rstn = 0, ds = 0, ce = 0, me = 0, te = 0, nm = 0, ae = 0;
	logic bm = 0, dn = 0, ls = 0, ext = 0, pin_n, req, sus;
	logic [3:0] sel = 4'h1, pc;
	logic [1:0] am;
	logic [9:0] up = 0, irq, cpu, clr;
	int miscompares = 0, checks = 0, i, n;
	always #2 clk = ~clk;
	dma_request_source_select dut (.clk_sys_in(clk), .resetn_in(rstn),
		.request_select_in(sel), .request_detect_select_in(ds),
		.channel_enable_bit_in(ce), .master_enable_bit_in(me),
		.transfer_end_flag_in(te), .nmi_seen_flag_in(nm),
		.address_error_flag_in(ae), .burst_mode_in(bm),
		.transfer_done_in(dn), .last_transfer_in(ls),
		.external_request_n_in(pin_n), .periph_irq_in(irq),
		.transfer_request_out(req), .address_mode_out(am),
		.pair_check_out(pc), .cpu_irq_out(cpu),
		.periph_clear_out(clr), .suspend_out(sus));
	req_partner prt (.clk_sys_in(clk), .raise_in(up), .clear_in(clr),
		.ext_in(ext), .irq_out(irq), .ext_n_out(pin_n));
	task step(int k); repeat (k) @(negedge clk); endtask
	task cmp(string s, logic [9:0] e, logic [9:0] v);
		checks++;
		if (v !== e) begin
			miscompares++;
			$display("mismatch %s exp %h got %h", s, e, v);
		end
	endtask
	task stop_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#20000 miscompares++;
		stop_test;
	end
	initial begin
		step(2); rstn = 1; ce = 1; me = 1; step(1);
		cmp("auto", 1, req);
		for (i = 0; i < 4; i++) begin
			{te, nm, ae, me} = 4'h1 ^ (4'h8 >> i); step(1);
			cmp("gate", 0, req);
		end
		{te, nm, ae, me} = 4'h1; ce = 0; step(1);
		cmp("suspend", 1, sus);
		ce = 1;
		for (i = 4; i < 6; i++) begin
			sel = i; step(1); cmp("unused", 0, req);
		end
		for (i = 0; i < 4; i++) if (i != 1) begin
			sel = i; step(1); cmp("mode", i ? i - 1 : 0, am);
		end
		sel = 0; ext = 1; step(4); cmp("level", 1, req);
		ext = 0; step(4); cmp("level", 0, req);
		// edge mode must give one request per fall, not a level
		ds = 1; ext = 1; n = 0;
		repeat (8) begin step(1); n += req; end
		cmp("edge", 1, n);
		for (i = 6; i < 16; i++) begin
			sel = i; up = 10'h3ff; step(1); up = 0; step(4);
			cmp("pair", i, pc);
			cmp("cpu", 10'h3ff ^ (10'h1 << (i - 6)), cpu);
			cmp("periph", 1, req);
			dn = 1; step(1); cmp("steal", 10'h1 << (i - 6), clr);
			// let the clear land before the next raise
			dn = 0; step(1);
		end
		up = 10'h3ff; bm = 1; dn = 1; step(1); up = 0;
		cmp("burst", 0, clr);
		ls = 1; step(1); cmp("burst", 10'h200, clr);
		dn = 0; step(1);
		stop_test;
	end
endmodule // tb_dma_request_source_select
